//--- pkg/epac_defines.svh
`ifndef EPAC_DEFINES_SVH
`define EPAC_DEFINES_SVH

// Register offsets on the software port (byte addresses).
`define EPAC_OFF_ACCUM 8'h00
`define EPAC_OFF_REC 8'h04
`define EPAC_OFF_PAGE 8'h08
`define EPAC_OFF_CTRL 8'h0c
`define EPAC_OFF_STATUS 8'h10

// Control and status bit positions.
`define EPAC_CTRL_ISSUE 0
`define EPAC_CTRL_LOCKED 1
`define EPAC_ST_BUSY 0
`define EPAC_ST_GP 1
`define EPAC_ST_PF 2
`define EPAC_ST_ZF 3
`define EPAC_ST_TGT 4

// Leaf index of the page accept operation.
`define EPAC_LEAF_ACCEPT 32'h00000005

// Security information record flag positions.
`define EPAC_F_R 0
`define EPAC_F_W 1
`define EPAC_F_X 2
`define EPAC_F_PEND 3
`define EPAC_F_MOD 4
`define EPAC_F_PR 5
`define EPAC_F_RSV_LO 6
`define EPAC_F_RSV_HI 7
`define EPAC_F_TYPE_LO 8
`define EPAC_F_TYPE_HI 15
`define EPAC_F_UPPER_LO 16

// Page type encodings.
`define EPAC_REGULAR_PAGE_TYPE 8'h01
`define EPAC_THREAD_CONTROL_PAGE_TYPE 8'h02
`define EPAC_TRIMMED_PAGE_TYPE 8'h04

// Alignment widths and segment limit pattern.
`define EPAC_REC_ALIGN 6
`define EPAC_PAGE_ALIGN 12
`define EPAC_SEG_LOW 12'hfff

// Reset values.
`define EPAC_RST_WORD 32'h00000000

`endif

//--- pkg/epac_pkg.sv
package epac_pkg;

    // One page cache map entry as seen by a lookup.
    typedef struct packed {
        logic valid;
        logic r;
        logic w;
        logic x;
        logic pending;
        logic modified;
        logic blocked;
        logic pr;
        logic [7:0] ptype;
        logic [31:0] owner;
        logic [31:0] lin_addr;
    } epac_entry_t;

    // Thread control fields read from the target page.
    typedef struct packed {
        logic reserved_nonzero;
        logic debug_opt_in_flag;
        logic [31:0] current_save_area_index;
        logic [31:0] save_area_count;
        logic [63:0] async_exit_pointer;
        logic [63:0] state;
        logic [31:0] first_segment_limit;
        logic [31:0] second_segment_limit;
    } epac_tcs_t;

    // Execution context of the issuing software.
    typedef struct packed {
        logic in_region;
        logic [31:0] range_base;
        logic [31:0] range_limit;
        logic [31:0] active_region_control;
        logic wide_mode_attribute;
    } epac_ctx_t;

    // Arithmetic flags returned at completion.
    typedef struct packed {
        logic zf;
        logic cf;
        logic pf;
        logic af;
        logic of;
        logic sf;
    } epac_flags_t;

    typedef enum logic [2:0] {
        EPAC_IDLE = 3'b000,
        EPAC_REC = 3'b001,
        EPAC_COPY = 3'b010,
        EPAC_TGT = 3'b011,
        EPAC_LOCK = 3'b100,
        EPAC_RECHK = 3'b101
    } epac_state_t;

    typedef enum logic [1:0] {
        EPAC_END_OK = 2'b00,
        EPAC_END_GP = 2'b01,
        EPAC_END_PF = 2'b10,
        EPAC_END_ZF = 2'b11
    } epac_end_t;

endpackage : epac_pkg

//--- core/epac_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "epac_defines.svh"

// Notes on behaviour
// - The operation faults unless issued from inside an isolated region.
// - A record address not aligned to 64 bytes gives a protection fault.
// - Record outside the linear range faults; not in the cache page-faults.
// - Record page must be valid, readable, settled, unblocked, regular, owned, matching.
// - The whole 64-byte record is copied to a 512-bit scratch first.
// - Any nonzero reserved field of the copied record gives a protection fault.
// - Target unaligned or out of range faults; not in cache page-faults.
// - Only regular with restrict or pending and unmodified, or thread control or trimmed with only modified set, are accepted.
// - Target entry must be valid, unblocked, of a known type and owned.
// - Target is taken exclusively against other modify leaves; conflict faults.
// - After locking, the target entry is rechecked for validity and ownership.
// - Attribute mismatch sets zero flag, returns mismatch code, leaves entry alone.
// - Incomplete tracking sets zero flag, returns tracking code, leaves entry alone.
// - A thread control target with nonzero reserved area faults.
// - Debug opt-in, save-area index, exit pointer and state must be sane.
// - Outside wide mode both segment limits must end in fffh.
// - Success clears pending, modified and restrict, clears zero flag and accumulator.
// - Zero flag only on refusal; other arithmetic flags cleared at any completion that does not fault.
// - A locked memory operand gives a protection fault.
module epac_core #(
    parameter logic [31:0] MISMATCH_CODE = 32'h00000001,
    parameter logic [31:0] NOT_TRACKED_CODE = 32'h00000002
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire epac_pkg::epac_ctx_t ctx_in,
    input wire logic rec_in_cache_in,
    input wire epac_pkg::epac_entry_t rec_entry_in,
    input wire logic [511:0] record_data_in,
    input wire logic tgt_in_cache_in,
    input wire epac_pkg::epac_entry_t tgt_entry_in,
    input wire epac_pkg::epac_tcs_t tgt_tcs_in,
    input wire logic page_in_use_in,
    input wire logic tracking_done_in,
    output logic [31:0] rec_addr_out,
    output logic [31:0] page_addr_out,
    output logic lock_out,
    output logic clear_out,
    output logic done_out,
    output logic gp_fault_out,
    output logic pf_fault_out,
    output logic [31:0] fault_addr_out,
    output logic [31:0] accum_out,
    output epac_pkg::epac_flags_t flags_out
);
    import epac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State.
    epac_state_t state_reg;
    epac_state_t state_next;
    logic [31:0] accum_reg;
    logic [31:0] rec_reg;
    logic [31:0] page_reg;
    logic locked_reg;
    logic [511:0] scratch_reg;
    logic [1:0] last_end_reg;
    logic last_tgt_reg;
    epac_flags_t flags_reg;
    logic fin;
    epac_end_t end_kind;
    logic on_tgt;
    logic [31:0] code;

    // A linear address lies within the region's range.
    function automatic logic in_range(input logic [31:0] a, input epac_ctx_t c);
        in_range = (a >= c.range_base) && (a <= c.range_limit);
    endfunction : in_range

    ////////////////////////////////////////////////////////////////////////
    // Register port decode.
    wire wr_accum = reg_wr_in && (reg_addr_in == `EPAC_OFF_ACCUM);
    wire wr_rec = reg_wr_in && (reg_addr_in == `EPAC_OFF_REC);
    wire wr_page = reg_wr_in && (reg_addr_in == `EPAC_OFF_PAGE);
    wire wr_ctrl = reg_wr_in && (reg_addr_in == `EPAC_OFF_CTRL);
    wire idle = (state_reg == EPAC_IDLE);
    wire issue = idle && wr_ctrl && reg_wdata_in[`EPAC_CTRL_ISSUE]
        && (accum_reg == `EPAC_LEAF_ACCEPT);
    wire [31:0] status_word = {27'h0000000, last_tgt_reg, flags_reg.zf,
        last_end_reg == EPAC_END_PF, last_end_reg == EPAC_END_GP, !idle};
    wire [31:0] rd_word = (reg_addr_in == `EPAC_OFF_ACCUM) ? accum_reg :
        (reg_addr_in == `EPAC_OFF_REC) ? rec_reg :
        (reg_addr_in == `EPAC_OFF_PAGE) ? page_reg :
        (reg_addr_in == `EPAC_OFF_CTRL) ? {30'h00000000, locked_reg, 1'b0} :
        (reg_addr_in == `EPAC_OFF_STATUS) ? status_word : `EPAC_RST_WORD;

    ////////////////////////////////////////////////////////////////////////
    // Check terms for the record page.
    wire rec_misaligned = |rec_reg[`EPAC_REC_ALIGN-1:0];
    wire rec_entry_bad = !rec_entry_in.valid || !rec_entry_in.r || rec_entry_in.pending
        || rec_entry_in.modified || rec_entry_in.blocked || (rec_entry_in.ptype != `EPAC_REGULAR_PAGE_TYPE)
        || (rec_entry_in.owner != ctx_in.active_region_control)
        || (rec_entry_in.lin_addr != {rec_reg[31:`EPAC_PAGE_ALIGN], 12'h000});

    // Fields of the copied record.
    wire [7:0] req_type = scratch_reg[`EPAC_F_TYPE_HI:`EPAC_F_TYPE_LO];
    wire req_pend = scratch_reg[`EPAC_F_PEND];
    wire req_mod = scratch_reg[`EPAC_F_MOD];
    wire req_pr = scratch_reg[`EPAC_F_PR];
    wire rec_rsv_nz = (|scratch_reg[511:`EPAC_F_UPPER_LO])
        || (|scratch_reg[`EPAC_F_RSV_HI:`EPAC_F_RSV_LO]);
    wire combo_ok = ((req_type == `EPAC_REGULAR_PAGE_TYPE) && (req_pr || req_pend) && !req_mod)
        || (((req_type == `EPAC_THREAD_CONTROL_PAGE_TYPE) || (req_type == `EPAC_TRIMMED_PAGE_TYPE))
        && !req_pr && !req_pend && req_mod);

    // Check terms for the target page.
    wire tgt_type_ok = (tgt_entry_in.ptype == `EPAC_REGULAR_PAGE_TYPE)
        || (tgt_entry_in.ptype == `EPAC_THREAD_CONTROL_PAGE_TYPE) || (tgt_entry_in.ptype == `EPAC_TRIMMED_PAGE_TYPE);
    wire tgt_owned = tgt_entry_in.valid && (tgt_entry_in.owner == ctx_in.active_region_control);
    wire tgt_entry_bad = !tgt_owned || tgt_entry_in.blocked || !tgt_type_ok;
    wire tgt_bad_addr = (|page_reg[`EPAC_PAGE_ALIGN-1:0]) || !in_range(page_reg, ctx_in);
    wire mismatch = (tgt_entry_in.lin_addr != page_reg) || (tgt_entry_in.pending != req_pend)
        || (tgt_entry_in.modified != req_mod) || (tgt_entry_in.r != scratch_reg[`EPAC_F_R])
        || (tgt_entry_in.w != scratch_reg[`EPAC_F_W]) || (tgt_entry_in.x != scratch_reg[`EPAC_F_X])
        || (tgt_entry_in.ptype != req_type);
    // Thread control fields matter only when a thread control page is accepted.
    wire is_tcs = (req_type == `EPAC_THREAD_CONTROL_PAGE_TYPE);
    wire tcs_bad = is_tcs && (tgt_tcs_in.reserved_nonzero
        || tgt_tcs_in.debug_opt_in_flag || (|tgt_tcs_in.async_exit_pointer) || (|tgt_tcs_in.state)
        || (tgt_tcs_in.current_save_area_index >= tgt_tcs_in.save_area_count)
        || (!ctx_in.wide_mode_attribute
        && ((tgt_tcs_in.first_segment_limit[11:0] != `EPAC_SEG_LOW)
        || (tgt_tcs_in.second_segment_limit[11:0] != `EPAC_SEG_LOW))));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: each state runs its checks in order and ends on the first failure.
    always_comb begin
        state_next = state_reg;
        fin = 1'b0;
        end_kind = EPAC_END_OK;
        on_tgt = 1'b0;
        code = `EPAC_RST_WORD;
        case (state_reg)
            EPAC_IDLE: begin
                if (issue) begin
                    state_next = EPAC_REC;
                end
            end
            EPAC_REC: begin
                fin = 1'b1;
                if (!ctx_in.in_region) begin
                    end_kind = EPAC_END_GP;
                end else if (locked_reg) begin
                    end_kind = EPAC_END_GP;
                end else if (rec_misaligned || !in_range(rec_reg, ctx_in)) begin
                    end_kind = EPAC_END_GP;
                end else if (!rec_in_cache_in || rec_entry_bad) begin
                    end_kind = EPAC_END_PF;
                end else begin
                    fin = 1'b0;
                    state_next = EPAC_COPY;
                end
            end
            EPAC_COPY: begin
                state_next = EPAC_TGT;
            end
            EPAC_TGT: begin
                fin = 1'b1;
                on_tgt = 1'b1;
                if (rec_rsv_nz || tgt_bad_addr) begin
                    end_kind = EPAC_END_GP;
                end else if (!tgt_in_cache_in) begin
                    end_kind = EPAC_END_PF;
                end else if (!combo_ok) begin
                    end_kind = EPAC_END_GP;
                end else if (tgt_entry_bad) begin
                    end_kind = EPAC_END_PF;
                end else begin
                    fin = 1'b0;
                    state_next = EPAC_LOCK;
                end
            end
            EPAC_LOCK: begin
                if (page_in_use_in) begin
                    fin = 1'b1;
                    on_tgt = 1'b1;
                    end_kind = EPAC_END_GP;
                end else begin
                    state_next = EPAC_RECHK;
                end
            end
            EPAC_RECHK: begin
                fin = 1'b1;
                on_tgt = 1'b1;
                if (!tgt_owned) begin
                    end_kind = EPAC_END_PF;
                end else if (mismatch) begin
                    end_kind = EPAC_END_ZF;
                    code = MISMATCH_CODE;
                end else if (!tracking_done_in) begin
                    end_kind = EPAC_END_ZF;
                    code = NOT_TRACKED_CODE;
                end else if (tcs_bad) begin
                    end_kind = EPAC_END_GP;
                end
            end
            default: begin
                state_next = EPAC_IDLE;
            end
        endcase
        if (fin) begin
            state_next = EPAC_IDLE;
        end
    end

    wire commit = fin && (end_kind == EPAC_END_OK);
    wire faulted = fin && ((end_kind == EPAC_END_GP) || (end_kind == EPAC_END_PF));

    ////////////////////////////////////////////////////////////////////////
    // Software registers; hardware results replace the accumulator at any completion that does not fault.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            accum_reg <= `EPAC_RST_WORD;
            rec_reg <= `EPAC_RST_WORD;
            page_reg <= `EPAC_RST_WORD;
            locked_reg <= 1'b0;
        end else begin
            if (fin && !faulted) begin
                accum_reg <= code;
            end else if (wr_accum && idle) begin
                accum_reg <= reg_wdata_in;
            end
            if (wr_rec && idle) begin
                rec_reg <= reg_wdata_in;
            end
            if (wr_page && idle) begin
                page_reg <= reg_wdata_in;
            end
            if (wr_ctrl && idle) begin
                locked_reg <= reg_wdata_in[`EPAC_CTRL_LOCKED];
            end
        end
    end

    // Sequencer state and the record scratch copy.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= EPAC_IDLE;
            scratch_reg <= 512'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == EPAC_COPY) begin
                scratch_reg <= record_data_in;
            end
        end
    end

    // Completion outputs; a faulting operation leaves flags and the entry as they were.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_reg <= '0;
            last_end_reg <= EPAC_END_OK;
            last_tgt_reg <= 1'b0;
            fault_addr_out <= `EPAC_RST_WORD;
            done_out <= 1'b0;
            gp_fault_out <= 1'b0;
            pf_fault_out <= 1'b0;
            clear_out <= 1'b0;
            lock_out <= 1'b0;
            reg_rdata_out <= `EPAC_RST_WORD;
        end else begin
            done_out <= fin;
            gp_fault_out <= fin && (end_kind == EPAC_END_GP);
            pf_fault_out <= fin && (end_kind == EPAC_END_PF);
            clear_out <= commit;
            lock_out <= (state_next == EPAC_RECHK);
            reg_rdata_out <= reg_rd_in ? rd_word : `EPAC_RST_WORD;
            if (fin) begin
                last_end_reg <= end_kind;
                last_tgt_reg <= on_tgt;
                fault_addr_out <= on_tgt ? page_reg : rec_reg;
            end
            if (fin && !faulted) begin
                flags_reg <= '{zf: (end_kind == EPAC_END_ZF), default: 1'b0};
            end
        end
    end

    assign rec_addr_out = rec_reg;
    assign page_addr_out = page_reg;
    assign accum_out = accum_reg;
    assign flags_out = flags_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer's behaviour.
    property p_leaf_gate;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (idle && wr_ctrl && (accum_reg != `EPAC_LEAF_ACCEPT)) |=> (state_reg == EPAC_IDLE);
    endproperty
    a_leaf_gate: assert property (p_leaf_gate) else $error("wrong leaf started");
    property p_outside;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == EPAC_REC && !ctx_in.in_region) |=> (gp_fault_out && done_out && !clear_out);
    endproperty
    a_outside: assert property (p_outside) else $error("outside region not faulted");
    property p_rec_align;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == EPAC_REC && ctx_in.in_region && !locked_reg && rec_misaligned) |=> gp_fault_out;
    endproperty
    a_rec_align: assert property (p_rec_align) else $error("misaligned record accepted");
    property p_copy;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == EPAC_COPY) |=> (scratch_reg == $past(record_data_in)) && (state_reg == EPAC_TGT);
    endproperty
    a_copy: assert property (p_copy) else $error("record copy lost");
    property p_rsv;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == EPAC_TGT && rec_rsv_nz) |=> (gp_fault_out && !lock_out);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved record bits ignored");
    property p_conflict;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == EPAC_LOCK && page_in_use_in) |=> (gp_fault_out && !lock_out && idle);
    endproperty
    a_conflict: assert property (p_conflict) else $error("lock conflict not faulted");
    property p_refuse;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (done_out && flags_out.zf && !gp_fault_out && !pf_fault_out) |-> (!clear_out
            && ((accum_out == MISMATCH_CODE) || (accum_out == NOT_TRACKED_CODE)));
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal changed entry");
    property p_commit;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        clear_out |-> (done_out && (accum_out == 32'h00000000) && !flags_out.zf && $past(lock_out));
    endproperty
    a_commit: assert property (p_commit) else $error("bad success completion");
    property p_flags;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (done_out && !gp_fault_out && !pf_fault_out) |-> (flags_out[4:0] == 5'h00);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not cleared");

endmodule : epac_core
`default_nettype wire

//--- dv/epac_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "epac_defines.svh"

// Software that issues the accept leaf over the register port, one access at a time.
module epac_sw_model (
    input wire logic ref_clk_in,
    output logic [7:0] reg_addr_out,
    output logic [31:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [31:0] reg_rdata_in
);
    // Idle bus from time zero so nothing is taken during reset.
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 32'h00000000;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // One write cycle; the strobe drops at the next edge, so calls never overlap.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_out <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_out <= 1'b0;
        #1 d = reg_rdata_in;
    endtask : rd_reg

    // Leaf index into the accumulator, both addresses, then the issue bit.
    task automatic issue(input logic [31:0] leaf, input logic [31:0] ra, input logic [31:0] pa, input logic lk);
        wr_reg(`EPAC_OFF_ACCUM, leaf);
        wr_reg(`EPAC_OFF_REC, ra);
        wr_reg(`EPAC_OFF_PAGE, pa);
        wr_reg(`EPAC_OFF_CTRL, {30'h0, lk, 1'b1});
    endtask : issue
endmodule : epac_sw_model
`default_nettype wire

//--- dv/epac_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "epac_defines.svh"

module epac_core_bench;
    import epac_pkg::*;
    typedef struct packed {
        epac_end_t kind;
        logic [31:0] acc;
        logic zf;
        logic [7:0] lat;
        logic [31:0] fa;
        logic [31:0] ra;
        logic [31:0] pa;
    } epac_note_t;
    localparam logic [31:0] MIS = 32'h00000001;
    localparam logic [31:0] NTR = 32'h00000002;
    // Outcome per scenario: 0 ok, 1 protection fault, 2 page fault, 3 zero flag.
    localparam bit [1:0] KD [27] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 1, 1, 1, 2, 1, 2, 2, 1, 3, 3, 1, 1, 1, 1, 0, 1, 0};
    // Cycles from issue to completion; 0 where the stage is not pinned down.
    localparam int LT [27] = '{6, 6, 6, 2, 2, 2, 2, 2, 2, 2, 0, 0, 4, 4, 0, 4, 4, 5, 6, 6, 6, 6, 6, 6, 6, 0, 6};
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] a_bus;
    logic [31:0] wd_bus;
    logic [31:0] rd_bus;
    logic wr_stb;
    logic rd_stb;
    epac_ctx_t ctx = '0;
    epac_entry_t rec_ent = '0;
    epac_entry_t tgt_ent = '0;
    epac_tcs_t tcs = '0;
    logic [511:0] rec_dat = '0;
    logic rec_hit = 1'b0;
    logic tgt_hit = 1'b0;
    logic in_use = 1'b0;
    logic trk = 1'b0;
    logic clear, done, gp, pf;
    logic [31:0] accum;
    logic [31:0] fa_o;
    logic [31:0] ra_o;
    logic [31:0] pa_o;
    logic lk_o;
    // Set when the lock is seen held during the operation now in flight.
    logic lk_seen = 1'b0;
    epac_flags_t flags;
    epac_note_t q[$];
    epac_note_t n;
    int errors = 0;
    int n_compared = 0;
    int seed = 44102;
    logic last_zf = 1'b0;
    time issue_t = 0;

    epac_sw_model sw (.ref_clk_in(ref_clk_in), .reg_addr_out(a_bus), .reg_wdata_out(wd_bus),
        .reg_wr_out(wr_stb), .reg_rd_out(rd_stb), .reg_rdata_in(rd_bus));

    epac_core #(.MISMATCH_CODE(MIS), .NOT_TRACKED_CODE(NTR)) uut (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(a_bus), .reg_wdata_in(wd_bus), .reg_wr_in(wr_stb),
        .reg_rd_in(rd_stb), .reg_rdata_out(rd_bus), .ctx_in(ctx), .rec_in_cache_in(rec_hit),
        .rec_entry_in(rec_ent), .record_data_in(rec_dat), .tgt_in_cache_in(tgt_hit), .tgt_entry_in(tgt_ent),
        .tgt_tcs_in(tcs), .page_in_use_in(in_use), .tracking_done_in(trk), .rec_addr_out(ra_o),
        .page_addr_out(pa_o), .lock_out(lk_o), .clear_out(clear), .done_out(done), .gp_fault_out(gp),
        .pf_fault_out(pf), .fault_addr_out(fa_o), .accum_out(accum), .flags_out(flags));

    // Free running processor clock.
    always #5 ref_clk_in = ~ref_clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_end(input logic [159:0] got, input logic [159:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t end %h exp %h", $time, got, exp);
        end
    endtask : check_end

    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t read %h exp %h", $time, got, exp);
        end
    endtask : check_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        sw.rd_reg(a, v);
        check_rd(v, e);
    endtask : rd_chk

    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Builds a page that passes every check, breaks at most one thing, notes the expected outcome, then issues.
    task automatic run(input int k);
        epac_ctx_t c;
        epac_entry_t re;
        epac_entry_t te;
        epac_tcs_t t;
        logic [511:0] d;
        logic [7:0] ty;
        logic [31:0] ra;
        logic [31:0] pa;
        logic [31:0] acc;
        logic [2:0] rwx;
        logic rh, th, us, tk, lk, pd, pn, prr;
        epac_end_t kd;
        ty = (k == 1 || (k >= 20 && k <= 24)) ? `EPAC_THREAD_CONTROL_PAGE_TYPE : (k == 2 ? `EPAC_TRIMMED_PAGE_TYPE : `EPAC_REGULAR_PAGE_TYPE);
        pd = (ty == `EPAC_REGULAR_PAGE_TYPE);
        pn = pd && k != 26;
        prr = (k == 26);
        rwx = 3'($random(seed));
        ra = {20'h00100, 6'($random(seed)), 6'h00};
        pa = {16'h0011, 4'($random(seed)), 12'h000};
        c = '{1'b1, 32'h00100000, 32'h001fffff, 32'h000000a5, !(k == 23 || k == 24)};
        re = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, `EPAC_REGULAR_PAGE_TYPE, 32'h000000a5, 32'h00100000};
        te = '{1'b1, rwx[0], rwx[1], rwx[2], pn, ~pd, 1'b0, prr, ty, 32'h000000a5, pa};
        t = '{1'b0, 1'b0, 32'h0, 32'h1, 64'h0, 64'h0, 32'h00000fff, 32'h00000fff};
        d = {496'h0, ty, 2'b00, prr, ~pd, pn, rwx};
        rh = 1'b1;
        th = 1'b1;
        us = 1'b0;
        tk = 1'b1;
        lk = 1'b0;
        case (k)
            3: c.in_region = 1'b0;
            4: ra = ra + 32'h8;
            5: ra = 32'h00200000;
            6: rh = 1'b0;
            7: re.pending = 1'b1;
            8: re.ptype = `EPAC_THREAD_CONTROL_PAGE_TYPE;
            9: re.lin_addr = 32'h00101000;
            10: d[6] = 1'b1;
            11: d[511] = 1'b1;
            12: pa = pa + 32'h4;
            13: th = 1'b0;
            14: d[4] = 1'b1;
            15: te.blocked = 1'b1;
            16: te.owner = 32'h0000005a;
            17: us = 1'b1;
            18: te.w = ~te.w;
            19: tk = 1'b0;
            20: t.reserved_nonzero = 1'b1;
            21: t.debug_opt_in_flag = 1'b1;
            22: t.current_save_area_index = 32'h1;
            23: t.first_segment_limit = 32'h00001ffe;
            24: t.second_segment_limit = 32'h0000afff;
            25: lk = 1'b1;
            default: ;
        endcase
        kd = epac_end_t'(KD[k]);
        // Faults leave the accumulator holding the leaf index and the flags as they were.
        acc = (kd == EPAC_END_GP || kd == EPAC_END_PF) ? 32'h5 : (kd == EPAC_END_ZF ? (k == 18 ? MIS : NTR) : 32'h0);
        if (kd == EPAC_END_OK) last_zf = 1'b0;
        if (kd == EPAC_END_ZF) last_zf = 1'b1;
        @(posedge ref_clk_in);
        ctx <= c;
        rec_ent <= re;
        tgt_ent <= te;
        tcs <= t;
        rec_dat <= d;
        rec_hit <= rh;
        tgt_hit <= th;
        in_use <= us;
        trk <= tk;
        // Record-stage endings report the record address, all later ones the target address.
        q.push_back('{kd, acc, last_zf, 8'(LT[k]), ((k >= 3 && k <= 9) || k == 25) ? ra : pa, ra, pa});
        sw.issue(32'h00000005, ra, pa, lk);
        issue_t = $time;
        for (int i = 0; i < 12 && q.size() != 0; i++) @(negedge ref_clk_in);
        if (q.size() != 0) check_end(160'h1, 160'h0);
        q.delete();
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    // Every completion pulse retires the oldest note; a pulse with no note is itself a mismatch.
    // Latency counts from the cycle in which the issue strobe stands; the lock is due only on the full path.
    always @(negedge ref_clk_in) begin
        if (lk_o === 1'b1) lk_seen = 1'b1;
        if (done === 1'b1) begin
            if (q.size() == 0) begin
                check_end(160'h1, 160'h0);
            end else begin
                n = q.pop_front();
                check_end({gp, pf, clear, flags, accum, (n.lat == 8'h0) ? 8'h0 : 8'(($time - issue_t + 5) / 10),
                    fa_o, ra_o, pa_o, lk_seen},
                    {n.kind == EPAC_END_GP, n.kind == EPAC_END_PF, n.kind == EPAC_END_OK, n.zf, 5'h0, n.acc,
                    n.lat, n.fa, n.ra, n.pa, n.lat == 8'h6});
            end
            lk_seen = 1'b0;
        end
    end

    // Whole run is some four hundred cycles; this cuts a hang well past that.
    initial begin
        #50000;
        errors++;
        print_verdict();
    end

    // Reset, the scenario table, a wrong leaf index, then register reads.
    initial begin
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        for (int k = 0; k < 27; k++) begin
            run(k);
            if (k == 6) rd_chk(`EPAC_OFF_STATUS, 32'h00000004);
            if (k == 25) rd_chk(`EPAC_OFF_CTRL, 32'h00000002);
        end
        sw.issue(32'h00000003, 32'h00100000, 32'h00110000, 1'b0);
        repeat (10) @(negedge ref_clk_in);
        rd_chk(`EPAC_OFF_ACCUM, 32'h00000003);
        rd_chk(8'h14, 32'h00000000);
        print_verdict();
    end
endmodule : epac_core_bench
`default_nettype wire
